// ### hw/dcr_defines.svh
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

// register addresses as they appear in the frame header
`define DCR_ADDR_LOAD_CONTROL 7'h04
`define DCR_ADDR_KIND_POWER 7'h05
`define DCR_ADDR_RESET_STROBES 7'h06
`define DCR_ADDR_DATA_CH0 7'h07
`define DCR_NUM_CHANNELS 4

// field positions
`define DCR_LOAD_STROBE_MSB 15
`define DCR_LOAD_STROBE_LSB 12
`define DCR_KIND_MSB 15
`define DCR_KIND_LSB 12
`define DCR_POWER_MSB 11
`define DCR_POWER_LSB 8
`define DCR_DATA_CLEAR_BIT 12
`define DCR_DEVICE_RESET_BIT 8

// reset values
`define DCR_KIND_RESET 4'h0
`define DCR_POWER_RESET 4'h0

// frame lengths in serial clock cycles, and the zero-based index of the last header bit
`define DCR_FRAME_BITS_PLAIN 6'h18
`define DCR_FRAME_BITS_CHECKED 6'h20
`define DCR_HEADER_LAST_BIT 6'h07

`endif

// ### hw/dcr_pkg.sv
package dcr_pkg;

    typedef enum logic [0:0] {
        DCR_IDLE = 1'b0,
        DCR_FRAME = 1'b1
    } dcr_phase_type;

    typedef struct packed {
        logic [3:0] kind;
        logic [3:0] power;
    } dcr_chan_ctl_type;

    typedef struct packed {
        dcr_phase_type phase;
        logic [5:0] bit_count;
        logic [31:0] shift_in;
        logic [15:0] shift_out;
        logic sclk_prev;
        logic latch_pin_prev;
        logic miso;
        dcr_chan_ctl_type ctl;
        logic [3:0] dac_load;
        logic [3:0] data_write;
        logic [15:0] data_word;
        logic data_clear;
        logic device_reset;
    } dcr_state_type;

endpackage : dcr_pkg

// ### hw/dcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcr_defines.svh"

module dcr_regs (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    output logic SPI_MISO_OE,
    input wire logic [3:0] LATCH_TRANSPARENT_CFG,
    input wire logic FRAME_CHECK_EN,
    input wire logic OVERCURRENT_RESPONSE_CFG,
    input wire logic [3:0] OVERCURRENT_DET,
    input wire logic LATCH_LOAD_PIN,
    output logic [3:0] DAC_LOAD,
    output logic [3:0] DATA_WRITE,
    output logic [15:0] DATA_WORD,
    output logic DATA_CLEAR,
    output logic DEVICE_RESET,
    output dcr_pkg::dcr_chan_ctl_type CHANNEL_CTL
);
    import dcr_pkg::*;

    dcr_state_type s;
    dcr_state_type next_s;

    function automatic logic [6:0] frame_addr(input logic [31:0] sr, input logic checked);
        frame_addr = checked ? sr[31:25] : sr[23:17];
    endfunction : frame_addr

    function automatic logic frame_is_read(input logic [31:0] sr, input logic checked);
        frame_is_read = checked ? sr[24] : sr[16];
    endfunction : frame_is_read

    function automatic logic [15:0] frame_data(input logic [31:0] sr, input logic checked);
        frame_data = checked ? sr[23:8] : sr[15:0];
    endfunction : frame_data

    logic sclk_rise;
    logic sclk_fall;
    logic latch_pin_rise;
    logic frame_done;
    logic frame_whole;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic [15:0] readback;
    logic [5:0] expected_bits;

    always_comb begin
        sclk_rise = SPI_SCLK && !s.sclk_prev;
        sclk_fall = !SPI_SCLK && s.sclk_prev;
        latch_pin_rise = LATCH_LOAD_PIN && !s.latch_pin_prev;
        expected_bits = FRAME_CHECK_EN ? `DCR_FRAME_BITS_CHECKED : `DCR_FRAME_BITS_PLAIN;
        frame_done = (s.phase == DCR_FRAME) && SPI_CS_N;
        // short or long frames are dropped whole rather than half applied
        frame_whole = (s.bit_count == expected_bits);
        addr = frame_addr(s.shift_in, FRAME_CHECK_EN);
        wdata = frame_data(s.shift_in, FRAME_CHECK_EN);
        // the header byte sits in the low bits once eight bits are in
        readback = header_readback(s.shift_in[7:1], s.ctl);
    end

    always_comb begin
        next_s = s;
        next_s.sclk_prev = SPI_SCLK;
        next_s.latch_pin_prev = LATCH_LOAD_PIN;
        next_s.data_write = 4'h0;
        next_s.data_clear = 1'b0;
        next_s.device_reset = 1'b0;
        // strobes exist only as one-cycle pulses, so nothing is left to read back
        next_s.dac_load = latch_pin_rise ? ~LATCH_TRANSPARENT_CFG : 4'h0;
        unique case (s.phase)
            DCR_IDLE: begin
                if (!SPI_CS_N) begin
                    next_s.phase = DCR_FRAME;
                    next_s.bit_count = 6'h00;
                    next_s.shift_in = 32'h0000_0000;
                    next_s.shift_out = 16'h0000;
                    next_s.miso = 1'b0;
                end
            end
            DCR_FRAME: begin
                if (sclk_rise) begin
                    next_s.shift_in = {s.shift_in[30:0], SPI_MOSI};
                    if (s.bit_count != 6'h3f) begin
                        next_s.bit_count = s.bit_count + 6'h01;
                    end
                end
                // header complete: the first fall after it puts the msb out,
                // so the host sees it before its ninth rising edge
                if (sclk_fall && s.bit_count == `DCR_HEADER_LAST_BIT + 6'h01 &&
                    frame_is_read_hdr(s.shift_in)) begin
                    next_s.miso = readback[15];
                    next_s.shift_out = {readback[14:0], 1'b0};
                end else if (sclk_fall && s.bit_count > 6'h08) begin
                    next_s.miso = s.shift_out[15];
                    next_s.shift_out = {s.shift_out[14:0], 1'b0};
                end
                if (frame_done) begin
                    next_s.phase = DCR_IDLE;
                    next_s.miso = 1'b0;
                    if (frame_whole && !frame_is_read(s.shift_in, FRAME_CHECK_EN)) begin
                        if (addr == `DCR_ADDR_LOAD_CONTROL) begin
                            next_s.dac_load = next_s.dac_load |
                                (wdata[`DCR_LOAD_STROBE_MSB:`DCR_LOAD_STROBE_LSB] &
                                 ~LATCH_TRANSPARENT_CFG);
                        end
                        if (addr == `DCR_ADDR_KIND_POWER) begin
                            next_s.ctl.kind = wdata[`DCR_KIND_MSB:`DCR_KIND_LSB];
                            next_s.ctl.power = wdata[`DCR_POWER_MSB:`DCR_POWER_LSB];
                        end
                        for (int i = 0; i < `DCR_NUM_CHANNELS; i++) begin
                            if (addr == `DCR_ADDR_DATA_CH0 + 7'(i)) begin
                                next_s.data_write[i] = 1'b1;
                                next_s.data_word = wdata;
                                next_s.dac_load[i] = next_s.dac_load[i] |
                                    LATCH_TRANSPARENT_CFG[i];
                            end
                        end
                        if (addr == `DCR_ADDR_RESET_STROBES) begin
                            if (wdata[`DCR_DATA_CLEAR_BIT]) begin
                                next_s.data_clear = 1'b1;
                                next_s.dac_load = 4'h0;
                                next_s.data_write = 4'h0;
                            end
                            if (wdata[`DCR_DEVICE_RESET_BIT]) begin
                                // frame-check, transparent-latch and overcurrent settings live outside and ignore this
                                next_s.device_reset = 1'b1;
                                next_s.dac_load = 4'h0;
                                next_s.ctl.kind = `DCR_KIND_RESET;
                                next_s.ctl.power = `DCR_POWER_RESET;
                            end
                        end
                    end
                end
            end
        endcase
        // overcurrent wins over a same-cycle host rewrite so a fault is never missed
        if (OVERCURRENT_RESPONSE_CFG) begin
            next_s.ctl.power = next_s.ctl.power & ~OVERCURRENT_DET;
        end
    end

    function automatic logic frame_is_read_hdr(input logic [31:0] sr);
        frame_is_read_hdr = sr[0];
    endfunction : frame_is_read_hdr

    // only kind and power are readable; strobes and reserved bits read 0
    function automatic logic [15:0] header_readback(
        input logic [6:0] a,
        input dcr_chan_ctl_type c
    );
        header_readback = 16'h0000;
        if (a == `DCR_ADDR_KIND_POWER) begin
            header_readback[`DCR_KIND_MSB:`DCR_KIND_LSB] = c.kind;
            header_readback[`DCR_POWER_MSB:`DCR_POWER_LSB] = c.power;
        end
    endfunction : header_readback

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        SPI_MISO = s.miso;
        SPI_MISO_OE = (s.phase == DCR_FRAME) && !SPI_CS_N;
        DAC_LOAD = s.dac_load;
        DATA_WRITE = s.data_write;
        DATA_WORD = s.data_word;
        DATA_CLEAR = s.data_clear;
        DEVICE_RESET = s.device_reset;
        CHANNEL_CTL = s.ctl;
    end

endmodule : dcr_regs
`default_nettype wire

// ### test/dcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_host (
    input wire logic clk,
    input wire logic miso,
    output logic cs_n,
    output logic sclk,
    output logic mosi
);
    initial {cs_n, sclk, mosi} = 3'b100;
    // three cycles per level so the sampler sees every sclk edge
    task automatic xfer(input logic [31:0] sh, input logic [5:0] n, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi <= sh[31 - i];
            repeat (3) @(posedge clk);
            if (i > 7 && i < 24) rd = {rd[14:0], miso};
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
    endtask : xfer
endmodule : dcr_host
`default_nettype wire

// ### test/dcr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_regs_chk (
    input wire logic CLK_SYS, input wire logic SYS_RST, input wire logic SPI_CS_N,
    input wire logic [3:0] LATCH_TRANSPARENT_CFG, input wire logic OVERCURRENT_RESPONSE_CFG,
    input wire logic [3:0] OVERCURRENT_DET, input wire logic [3:0] DAC_LOAD,
    input wire logic [3:0] DATA_WRITE, input wire logic DATA_CLEAR,
    input wire logic DEVICE_RESET, input wire dcr_pkg::dcr_chan_ctl_type CHANNEL_CTL
);
    import dcr_pkg::*;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    logic [3:0] tw;
    assign tw = DATA_WRITE & LATCH_TRANSPARENT_CFG;
    sequence frame_end;
        !SPI_CS_N ##1 SPI_CS_N;
    endsequence
    load_pulse_a: assert property (DAC_LOAD != 4'h0 |=> DAC_LOAD == 4'h0) else $error("load");
    clear_pulse_a: assert property (DATA_CLEAR |=> !DATA_CLEAR) else $error("clear");
    reset_pulse_a: assert property (DEVICE_RESET |=> !DEVICE_RESET) else $error("reset");
    clear_time_a: assert property (DATA_CLEAR |-> $past(SPI_CS_N) && !$past(SPI_CS_N, 2))
        else $error("clear timing");
    clear_noload_a: assert property (DATA_CLEAR |-> DAC_LOAD == 4'h0) else $error("noload");
    reset_ctl_a: assert property (frame_end ##1 DEVICE_RESET |-> CHANNEL_CTL == 8'h00)
        else $error("reset ctl");
    transp_load_a: assert property (tw != 4'h0 |-> (DAC_LOAD & tw) == tw) else $error("tl");
    ovc_clear_a: assert property ((OVERCURRENT_RESPONSE_CFG && OVERCURRENT_DET != 4'h0)
        ##1 $stable(OVERCURRENT_DET) |-> (CHANNEL_CTL.power & OVERCURRENT_DET) == 4'h0)
        else $error("overcurrent");
endmodule : dcr_regs_chk
bind dcr_regs dcr_regs_chk i_dcr_regs_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .SPI_CS_N(SPI_CS_N), .LATCH_TRANSPARENT_CFG(LATCH_TRANSPARENT_CFG),
    .OVERCURRENT_RESPONSE_CFG(OVERCURRENT_RESPONSE_CFG), .OVERCURRENT_DET(OVERCURRENT_DET),
    .DAC_LOAD(DAC_LOAD), .DATA_WRITE(DATA_WRITE), .DATA_CLEAR(DATA_CLEAR),
    .DEVICE_RESET(DEVICE_RESET), .CHANNEL_CTL(CHANNEL_CTL));
`default_nettype wire

// ### test/test_dcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_dcr_regs;
    import dcr_pkg::*;
    typedef struct packed {logic [31:0] sh; logic [1:0] fmt; logic [15:0] exp;} dcr_row_type;
    dcr_row_type rows [8];
    logic clk = 1'b0, rst = 1'b1, fce = 1'b0, ovc_cfg = 1'b0, pin = 1'b0;
    logic cs_n, sclk, mosi, miso, oe, data_clear, device_reset;
    logic [3:0] lt_cfg = 4'h0, ovc_det = 4'h0, dac_load, data_write, seen_ld, seen_dw;
    logic [1:0] seen_cr;
    logic [15:0] data_word, rd;
    dcr_chan_ctl_type ctl;
    int failures = 0, tests_run = 0, cycles = 0;
    dcr_host i_dcr_host (.clk(clk), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
    dcr_regs i_dcr_regs (.CLK_SYS(clk), .SYS_RST(rst), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
        .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(oe), .LATCH_TRANSPARENT_CFG(lt_cfg),
        .FRAME_CHECK_EN(fce), .OVERCURRENT_RESPONSE_CFG(ovc_cfg), .OVERCURRENT_DET(ovc_det),
        .LATCH_LOAD_PIN(pin), .DAC_LOAD(dac_load), .DATA_WRITE(data_write),
        .DATA_WORD(data_word), .DATA_CLEAR(data_clear), .DEVICE_RESET(device_reset),
        .CHANNEL_CTL(ctl));
    initial forever #10 clk = ~clk;
    // pulses last one cycle, so keep a sticky copy per frame
    always @(posedge clk) begin
        seen_ld <= seen_ld | dac_load;
        seen_dw <= seen_dw | data_write;
        seen_cr <= seen_cr | {data_clear, device_reset};
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input dcr_row_type r);
        @(posedge clk) fce <= r.fmt[1];
        @(negedge clk) {seen_ld, seen_cr, seen_dw} = 10'h000;
        i_dcr_host.xfer(r.sh, r.fmt[0] ? 6'h20 : 6'h18, rd);
        repeat (3) @(posedge clk);
        check(r.sh[24] ? rd : {ctl, seen_ld, 2'h0, seen_cr}, r.exp);
    endtask : run
    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        rows = '{'{32'h0af30000, 2'h0, 16'hf300},
            '{32'h08f00000, 2'h0, 16'hf3f0},
            '{32'h08000000, 2'h0, 16'hf300},
            '{32'h0c100000, 2'h0, 16'hf302},
            '{32'h0c010000, 2'h0, 16'h0001},
            '{32'h0a5a0000, 2'h2, 16'h0000},
            '{32'h0aa5ff00, 2'h3, 16'ha500},
            '{32'h0b000000, 2'h0, 16'ha500}};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) run(rows[i]);
        @(posedge clk) lt_cfg <= 4'h1;
        run('{32'h0e123000, 2'h0, 16'ha510});
        check(data_word, 16'h1230);
        check(16'(seen_dw), 16'h0001);
        @(posedge clk) lt_cfg <= 4'h5;
        run('{32'h10456000, 2'h0, 16'ha500});
        check(16'(seen_dw), 16'h0002);
        run('{32'h08f00000, 2'h0, 16'ha5a0});
        @(negedge clk) seen_ld = 4'h0;
        @(posedge clk) pin <= 1'b1;
        repeat (3) @(posedge clk);
        check(16'(seen_ld), 16'h000a);
        @(posedge clk) ovc_cfg <= 1'b1;
        ovc_det <= 4'h4;
        repeat (4) @(posedge clk);
        ovc_det <= 4'h0;
        check(16'(ctl), 16'h00a1);
        run('{32'h0aa50000, 2'h0, 16'ha500});
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        @(negedge clk) check(16'(ctl), 16'h0000);
        check(16'(oe), 16'h0000);
        end_of_test();
    end
endmodule : test_dcr_regs
`default_nettype wire
